//--- hdl/power_event_interrupts.sv
// supply event flags, interrupt output, bus gate and clock output control
`timescale 1ns/10ps
`default_nettype none
// Operation
// - switchover event only in modes 01/10
// - switchover sets flag, enabled raises interrupt
// - return debounce 1 ms, or 1000 ms if low
// - bus access only after main and debounce
// - power-up sets flag; enabled drives interrupt low
// - powerup flag holds until software clears
// - powerup flag interrupt follows its enable
// - powerup flag clears when supply collapses
// - powerup and low enables loaded from nonvolatile after start-up
// - clock pin hi-z, then low, then enabled
// - supply level sampled on 1 Hz tick
// - low supply stops compensation, clock, bus
// - sampled drop sets low flag; enabled raises interrupt
// - low flag holds until software writes zero
// - low enable kept in nonvolatile, mirrored
// - flag within 1 s; clock back within 1 s plus 1 ms delay
// - low flag interrupt follows its enable
// - low flag unreachable while bus disabled
// - power-up clears low flag
// - fast swings set no flag, clock immediate
module power_event_interrupts
    import power_event_pkg::*;
#(
    parameter logic [31:0] TICK_CYCLES  = power_event_pkg::TICK_CYC,
    parameter logic [31:0] START_CYCLES = power_event_pkg::START_CYC,
    parameter logic [31:0] HIZ_CYCLES   = power_event_pkg::POR_HIZ_CYC,
    parameter logic [31:0] DEB_S_CYCLES = power_event_pkg::DEB_SHORT_CYC,
    parameter logic [31:0] DEB_L_CYCLES = power_event_pkg::DEB_LONG_CYC,
    parameter logic [31:0] DLY_CYCLES   = power_event_pkg::CLK_DELAY_CYC
)(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic       i_backup_supply_state,
    input  wire logic       i_below_powerup_threshold,
    input  wire logic       i_below_supply_low_threshold,
    input  wire logic       i_clk_src,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    output logic            o_irq_n,
    output logic            o_clock_out_pin,
    output logic            o_clock_out_oe,
    output logic            o_temp_comp_en,
    output logic            o_bus_enabled
);
    import power_event_pkg::*;

    // ------------------------------------------------
    // pin synchronisers and edges
    // ------------------------------------------------
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [1:0] prev_q;
    logic       backup_s;
    logic       below_por_s;
    logic       below_low_s;
    logic       por_evt;
    logic       backup_rise;
    logic       backup_fall;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            prev_q  <= 2'h0;
        end
        else
        begin
            sync1_q <= {i_below_supply_low_threshold,
                        i_below_powerup_threshold,
                        i_backup_supply_state};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q[1:0];
        end
    end

    assign backup_s    = sync2_q[0];
    assign below_por_s = sync2_q[1];
    assign below_low_s = sync2_q[2];
    assign por_evt     = prev_q[1] & ~below_por_s;
    assign backup_rise = backup_s & ~prev_q[0];
    assign backup_fall = ~backup_s & prev_q[0];

    // ------------------------------------------------
    // 1 Hz tick
    // ------------------------------------------------
    logic [31:0] tick_cnt_q;
    logic        tick;

    assign tick = (tick_cnt_q == TICK_CYCLES - 32'h1);

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            tick_cnt_q <= 32'h0;
        else if (tick)
            tick_cnt_q <= 32'h0;
        else
            tick_cnt_q <= tick_cnt_q + 32'h1;
    end

    // ------------------------------------------------
    // sampled supply level
    // ------------------------------------------------
    logic low_q;
    logic low_evt;

    // a collapse past the power-up level skips the sample
    assign low_evt = tick & below_low_s & ~below_por_s;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            low_q <= 1'b0;
        else if (below_por_s | por_evt)
            low_q <= 1'b0;
        else if (tick)
            low_q <= below_low_s;
    end

    // compensation stops at once; only the flag and clock wait for a tick
    assign o_temp_comp_en = ~below_low_s & ~below_por_s;

    // ------------------------------------------------
    // return debounce
    // ------------------------------------------------
    logic [31:0] deb_cnt_q;
    logic        deb_busy_q;
    logic [31:0] deb_lim;
    logic        bus_ok;
    logic [2:0]  flags_q;

    assign deb_lim = flags_q[SUPPLY_LOW_BIT] ? DEB_L_CYCLES
                                             : DEB_S_CYCLES;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            deb_busy_q <= 1'b0;
            deb_cnt_q  <= 32'h0;
        end
        else if (backup_fall)
        begin
            deb_busy_q <= 1'b1;
            deb_cnt_q  <= 32'h0;
        end
        else if (deb_busy_q)
        begin
            if (deb_cnt_q >= deb_lim - 32'h1)
                deb_busy_q <= 1'b0;
            deb_cnt_q <= deb_cnt_q + 32'h1;
        end
    end

    assign bus_ok = ~backup_s & ~deb_busy_q & ~backup_fall
                  & ~below_por_s & ~low_q & ~below_low_s;
    assign o_bus_enabled = bus_ok;

    // ------------------------------------------------
    // start-up load of enable mirrors
    // ------------------------------------------------
    logic [31:0] start_cnt_q;
    logic        start_busy_q;
    logic        start_done;

    assign start_done = start_busy_q
                      & (start_cnt_q == START_CYCLES - 32'h1);

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            start_busy_q <= 1'b0;
            start_cnt_q  <= 32'h0;
        end
        else if (por_evt)
        begin
            start_busy_q <= 1'b1;
            start_cnt_q  <= 32'h0;
        end
        else if (start_done)
            start_busy_q <= 1'b0;
        else if (start_busy_q)
            start_cnt_q <= start_cnt_q + 32'h1;
    end

    // ------------------------------------------------
    // register writes
    // ------------------------------------------------
    logic       wr_ok;
    logic [2:0] flags_d;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    logic [2:0] enables_q;
    logic [1:0] mode_q;
    logic [1:0] nvcfg_q;
    logic       mode_ok;

    assign wr_ok   = i_wr & bus_ok;
    assign mode_ok = (mode_q == DIRECT_SWITCH_MODE)
                   | (mode_q == LEVEL_SWITCH_MODE);

    assign flag_set[POWERUP_BIT]    = por_evt;
    assign flag_set[SUPPLY_LOW_BIT] = low_evt;
    assign flag_set[SWITCHOVER_BIT] = backup_rise & mode_ok;

    // writing a zero clears a flag; writing a one leaves it alone
    assign flag_clr = (wr_ok && i_addr == STATUS_OFS)
                    ? ~i_wdata[2:0] : 3'h0;

    always_comb
    begin
        // an event in the clearing cycle still sets the flag
        flags_d = flag_set | (flags_q & ~flag_clr);
        if (below_por_s)
            flags_d[POWERUP_BIT] = 1'b0;
        if (por_evt)
            flags_d[SUPPLY_LOW_BIT] = 1'b0;
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            flags_q <= FLAGS_RST;
        else
            flags_q <= flags_d;
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            enables_q <= ENABLES_RST;
        else if (por_evt)
            enables_q <= ENABLES_RST;
        else if (start_done)
        begin
            enables_q[POWERUP_BIT]    <= nvcfg_q[POWERUP_BIT];
            enables_q[SUPPLY_LOW_BIT] <= nvcfg_q[SUPPLY_LOW_BIT];
        end
        else if (wr_ok && i_addr == CONTROL_OFS)
            enables_q <= i_wdata[2:0];
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            mode_q <= MODE_RST;
        else if (wr_ok && i_addr == MODE_OFS)
            mode_q <= i_wdata[1:0];
    end

    // nonvolatile byte survives power-up events, only i_rst clears it
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            nvcfg_q <= NVCFG_RST;
        else if (wr_ok && i_addr == NVCFG_OFS)
            nvcfg_q <= i_wdata[1:0];
    end

    // ------------------------------------------------
    // register reads
    // ------------------------------------------------
    clk_state_t ck_q;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            o_rdata <= 8'h00;
        else if (!(i_rd && bus_ok))
            o_rdata <= 8'h00;
        else
        begin
            case (i_addr)
                STATUS_OFS:  o_rdata <= {5'h00, flags_q};
                CONTROL_OFS: o_rdata <= {5'h00, enables_q};
                MODE_OFS:    o_rdata <= {6'h00, mode_q};
                NVCFG_OFS:   o_rdata <= {6'h00, nvcfg_q};
                STATE_OFS:   o_rdata <= {3'h0, start_busy_q, low_q,
                                         1'b0, ck_q};
                default:     o_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------
    // interrupt output
    // ------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            o_irq_n <= 1'b1;
        else
            o_irq_n <= ~|(flags_q & enables_q);
    end

    // ------------------------------------------------
    // clock output control
    // ------------------------------------------------
    logic [31:0] ck_cnt_q;
    logic        ck_off;

    // below the power-up level the pin drops without waiting a tick
    assign ck_off = low_q | below_por_s;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ck_q     <= CK_HIZ;
            ck_cnt_q <= 32'h0;
        end
        else if (por_evt)
        begin
            ck_q     <= CK_HIZ;
            ck_cnt_q <= 32'h0;
        end
        else
        begin
            case (ck_q)
                CK_HIZ:
                begin
                    ck_cnt_q <= ck_cnt_q + 32'h1;
                    if (ck_cnt_q == HIZ_CYCLES - 32'h1)
                    begin
                        ck_q     <= CK_LOW;
                        ck_cnt_q <= 32'h0;
                    end
                end
                CK_LOW:
                begin
                    if (ck_off)
                        ck_cnt_q <= 32'h0;
                    else if (ck_cnt_q == DLY_CYCLES - 32'h1)
                        ck_q <= CK_WAIT;
                    else
                        ck_cnt_q <= ck_cnt_q + 32'h1;
                end
                CK_WAIT:
                begin
                    // start on a low phase so no runt pulse escapes
                    if (ck_off)
                    begin
                        ck_q     <= CK_LOW;
                        ck_cnt_q <= 32'h0;
                    end
                    else if (!i_clk_src)
                        ck_q <= CK_RUN;
                end
                CK_RUN:
                begin
                    if (ck_off)
                    begin
                        ck_q     <= CK_LOW;
                        ck_cnt_q <= 32'h0;
                    end
                end
                default:
                begin
                    ck_q     <= CK_HIZ;
                    ck_cnt_q <= 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_clock_out_pin <= 1'b0;
            o_clock_out_oe  <= 1'b0;
        end
        else
        begin
            o_clock_out_pin <= (ck_q == CK_RUN) & ~ck_off & i_clk_src;
            o_clock_out_oe  <= (ck_q != CK_HIZ);
        end
    end

    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_switch_event;
        backup_rise && mode_ok;
    endsequence

    sequence s_return;
        backup_fall;
    endsequence

    a_switch_flag_set: assert property (
        s_switch_event |=> flags_q[SWITCHOVER_BIT])
        else $error("switchover flag not set");

    a_switch_mode_gate: assert property (
        $rose(flags_q[SWITCHOVER_BIT]) |-> $past(backup_rise && mode_ok))
        else $error("switchover flag set outside 01/10 mode");

    a_return_bus_block: assert property (
        s_return |-> !bus_ok ##1 !bus_ok)
        else $error("bus open during return debounce");

    a_debounce_end: assert property (
        deb_busy_q && deb_cnt_q >= deb_lim - 32'h1 && !backup_fall
        |=> !deb_busy_q)
        else $error("debounce outlasts its limit");

    a_por_flag_set: assert property (
        por_evt |=> flags_q[POWERUP_BIT] && !flags_q[SUPPLY_LOW_BIT])
        else $error("power-up flags wrong after power-up");

    a_por_auto_clr: assert property (
        below_por_s |=> !flags_q[POWERUP_BIT])
        else $error("powerup flag kept while supply collapsed");

    a_irq_follow: assert property (
        |(flags_q & enables_q) |=> !o_irq_n ##1 1'b1)
        else $error("interrupt not asserted for enabled flag");

    a_irq_release: assert property (
        flags_q == 3'h0 |=> o_irq_n)
        else $error("interrupt held with no flag set");

    a_low_flag_hold: assert property (
        flags_q[SUPPLY_LOW_BIT] && !flag_clr[SUPPLY_LOW_BIT]
        && !por_evt |=> flags_q[SUPPLY_LOW_BIT])
        else $error("supply low flag cleared itself");

    a_low_on_tick: assert property (
        $rose(flags_q[SUPPLY_LOW_BIT]) |-> $past(tick))
        else $error("supply low flag set off the tick");

    a_low_clock_off: assert property (
        low_q |=> !o_clock_out_pin)
        else $error("clock output runs while supply low");

    a_por_hiz: assert property (
        por_evt |=> ##1 !o_clock_out_oe [*2])
        else $error("clock pin driven right after power-up");

endmodule
`default_nettype wire

//--- inc/power_event_pkg.sv
// constants for the supply event flags and interrupt logic
package power_event_pkg;
    // ------------------------------------------------
    // register offsets
    // ------------------------------------------------
    localparam logic [7:0] STATUS_OFS  = 8'h00;
    localparam logic [7:0] CONTROL_OFS = 8'h01;
    localparam logic [7:0] MODE_OFS    = 8'h02;
    localparam logic [7:0] NVCFG_OFS   = 8'h03;
    localparam logic [7:0] STATE_OFS   = 8'h04;
    // ------------------------------------------------
    // field positions
    // ------------------------------------------------
    localparam int POWERUP_BIT = 0;
    localparam int SUPPLY_LOW_BIT = 1;
    localparam int SWITCHOVER_BIT = 2;
    localparam logic [1:0] DIRECT_SWITCH_MODE = 2'h1;
    localparam logic [1:0] LEVEL_SWITCH_MODE  = 2'h2;
    // ------------------------------------------------
    // reset values
    // ------------------------------------------------
    localparam logic [2:0] FLAGS_RST   = 3'h0;
    localparam logic [2:0] ENABLES_RST = 3'h0;
    localparam logic [1:0] MODE_RST    = 2'h0;
    localparam logic [1:0] NVCFG_RST   = 2'h0;
    // ------------------------------------------------
    // timing
    // ------------------------------------------------
    localparam logic [31:0] CLK_KHZ        = 32'd200000;
    localparam logic [31:0] TICK_MS        = 32'd1000;
    localparam logic [31:0] START_MS       = 32'd100;
    localparam logic [31:0] POR_HIZ_MS     = 32'd6;
    localparam logic [31:0] DEB_SHORT_MS   = 32'd1;
    localparam logic [31:0] DEB_LONG_MS    = 32'd1000;
    localparam logic [31:0] CLK_DELAY_MS   = 32'd1;
    localparam logic [31:0] TICK_CYC      = TICK_MS * CLK_KHZ;
    localparam logic [31:0] START_CYC     = START_MS * CLK_KHZ;
    localparam logic [31:0] POR_HIZ_CYC   = POR_HIZ_MS * CLK_KHZ;
    localparam logic [31:0] DEB_SHORT_CYC = DEB_SHORT_MS * CLK_KHZ;
    localparam logic [31:0] DEB_LONG_CYC  = DEB_LONG_MS * CLK_KHZ;
    localparam logic [31:0] CLK_DELAY_CYC = CLK_DELAY_MS * CLK_KHZ;
    // ------------------------------------------------
    // clock output states
    // ------------------------------------------------
    typedef enum logic [1:0] {
        CK_HIZ = 2'b00,
        CK_LOW = 2'b01,
        CK_WAIT = 2'b10,
        CK_RUN = 2'b11
    } clk_state_t;
endpackage

//--- verification/host_model.sv
// host processor model that drives the register bus of the block
`timescale 1ns/10ps
`default_nettype none
module host_model
    import power_event_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_rdata,
    output logic      [7:0] o_addr,
    output logic      [7:0] o_wdata,
    output logic            o_wr,
    output logic            o_rd
);
    // ------------------------------------------------
    // bus cycles
    // ------------------------------------------------
    initial
    begin
        o_addr = 8'h00;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    // released lines show the inverse so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_core_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_core_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_core_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        // read data stand only until the next edge
        #1;
        d = i_rdata;
    endtask

    // ------------------------------------------------
    // software procedures
    // ------------------------------------------------
    // powerup and low enables live in the nonvolatile byte, mirror alone is lost at power-up
    task automatic nv_program(input logic [1:0] en);
        wr(NVCFG_OFS, {6'h00, en});
    endtask

    // disable, clear flag, choose mode, then enable
    task automatic switch_setup(input logic [1:0] m, input logic ie);
        wr(CONTROL_OFS, 8'h00);
        wr(STATUS_OFS, 8'hfb);
        wr(MODE_OFS, {6'h00, m});
        wr(CONTROL_OFS, {5'h00, ie, 2'b00});
    endtask
endmodule
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the supply event interrupt block
`timescale 1ns/10ps
`default_nettype none
module tb;
    import power_event_pkg::*;
    // short counts keep the run small
    localparam int TICK = 20;
    localparam int START = 10;
    localparam int HIZ = 8;
    localparam int DEBS = 4;
    localparam int DEBL = 40;
    localparam int DLY = 4;
    logic        i_core_clk;
    logic        i_rst;
    logic        backup;
    logic        below_por;
    logic        below_low;
    logic        clk_src = 1'b0;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        wr;
    logic        rd;
    logic        irq_n;
    logic        ck_pin;
    logic        ck_oe;
    logic        comp_en;
    logic        bus_en;
    logic [31:0] seed;
    logic [7:0]  v;
    int          n;
    int          mismatches = 0;
    int          compares = 0;
    int          cycles = 0;

    power_event_interrupts #(.TICK_CYCLES(TICK), .START_CYCLES(START),
        .HIZ_CYCLES(HIZ), .DEB_S_CYCLES(DEBS), .DEB_L_CYCLES(DEBL),
        .DLY_CYCLES(DLY)) DUT (
        .i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_backup_supply_state(backup),
        .i_below_powerup_threshold(below_por),
        .i_below_supply_low_threshold(below_low),
        .i_clk_src(clk_src), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq_n(irq_n),
        .o_clock_out_pin(ck_pin), .o_clock_out_oe(ck_oe),
        .o_temp_comp_en(comp_en), .o_bus_enabled(bus_en));

    host_model host (.i_core_clk(i_core_clk), .i_rdata(rdata),
        .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic exp_switch(input logic [1:0] m);
        return (m == DIRECT_SWITCH_MODE) || (m == LEVEL_SWITCH_MODE);
    endfunction

    function automatic logic exp_irq_n(input logic [2:0] f,
                                       input logic [2:0] e);
        return ~|(f & e);
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, v);
        chk(v, exp);
    endtask

    // interrupt output settles one edge after the write lands; checked after two
    task automatic wr_irq(input logic [7:0] a, input logic [7:0] d,
                          input logic [7:0] exp);
        host.wr(a, d);
        repeat (2) @(posedge i_core_clk);
        #1;
        chk({7'h00, irq_n}, exp);
    endtask

    task automatic pins(input logic b, input logic p, input logic l);
        @(posedge i_core_clk);
        backup <= b;
        below_por <= p;
        below_low <= l;
    endtask

    // bounded wait: 0 for bus open, 1 for clock pin driven
    task automatic wait_for(input int which);
        n = 0;
        #1;
        while (((which == 0) ? bus_en : ck_oe) !== 1'b1 && n < 400)
        begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge i_core_clk);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------
    // clock, source square wave, hang guard
    // ------------------------------------------------
    initial
    begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end

    always @(posedge i_core_clk)
    begin
        clk_src <= ~clk_src;
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            mismatches = mismatches + 1;
            tally_and_finish();
        end
    end

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    initial
    begin
        i_rst = 1'b1;
        backup = 1'b0;
        below_por = 1'b0;
        below_low = 1'b0;
        seed = 32'd34;
        repeat (5) @(posedge i_core_clk);
        i_rst <= 1'b0;
        wait_for(1);
        chk({7'h00, n >= HIZ - 1 && n <= HIZ + 4}, 8'h01);
        chk({7'h00, ck_pin}, 8'h00);
        rd_chk(STATUS_OFS, 8'h00);
        rd_chk(CONTROL_OFS, 8'h00);
        rd_chk(MODE_OFS, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            seed = xorshift(seed);
            host.wr({1'b1, seed[6:0]}, seed[15:8]);
            rd_chk({1'b1, seed[6:0]}, 8'h00);
        end
        host.nv_program(2'b11);
        rd_chk(NVCFG_OFS, 8'h03);
        settle(DLY + 12);
        host.rd(STATE_OFS, v);
        chk({6'h00, v[1:0]}, {6'h00, CK_RUN});
        $display("test reset and clock output done");

        // every mode; only the two switching modes raise the event
        for (int m = 0; m < 4; m++)
        begin
            host.switch_setup(2'(m), 1'b1);
            pins(1'b1, 1'b0, 1'b0);
            settle(6);
            chk({7'h00, irq_n}, {7'h00, exp_irq_n({exp_switch(2'(m)), 2'b00}, 3'b100)});
            chk({7'h00, bus_en}, 8'h00);
            pins(1'b0, 1'b0, 1'b0);
            wait_for(0);
            chk({7'h00, n >= DEBS && n < DEBL}, 8'h01);
            rd_chk(STATUS_OFS, {5'h00, exp_switch(2'(m)), 2'b00});
        end
        $display("test switchover done");

        host.wr(CONTROL_OFS, 8'h00);
        host.wr(STATUS_OFS, 8'hfd);
        host.wr(CONTROL_OFS, 8'h02);
        pins(1'b0, 1'b0, 1'b1);
        settle(4);
        chk({6'h00, comp_en, bus_en}, 8'h00);
        settle(2 * TICK + 4);
        chk({7'h00, irq_n}, 8'h00);
        chk({7'h00, ck_pin}, 8'h00);
        pins(1'b0, 1'b0, 1'b0);
        wait_for(0);
        rd_chk(STATUS_OFS, 8'h02);
        pins(1'b1, 1'b0, 1'b0);
        settle(6);
        pins(1'b0, 1'b0, 1'b0);
        wait_for(0);
        chk({7'h00, n >= DEBL && n <= DEBL + 8}, 8'h01);
        rd_chk(STATUS_OFS, 8'h02);
        wr_irq(CONTROL_OFS, 8'h00, 8'h01);
        wr_irq(CONTROL_OFS, 8'h02, 8'h00);
        $display("test supply low done");

        pins(1'b0, 1'b1, 1'b0);
        settle(4);
        chk({7'h00, ck_pin}, 8'h00);
        settle(1);
        chk({7'h00, ck_pin}, 8'h00);
        settle(6);
        pins(1'b0, 1'b0, 1'b0);
        wait_for(0);
        settle(START + 12);
        chk({7'h00, irq_n}, 8'h00);
        rd_chk(CONTROL_OFS, 8'h03);
        rd_chk(STATUS_OFS, 8'h01);
        settle(30);
        rd_chk(STATUS_OFS, 8'h01);
        wr_irq(CONTROL_OFS, 8'h02, 8'h01);
        wr_irq(CONTROL_OFS, 8'h03, 8'h00);
        wr_irq(STATUS_OFS, 8'hfe, 8'h01);
        $display("test power-up done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
